// >>> verilog/two_wire_port.sv
// Two-wire serial port that acts as bus host or bus device.
// Assumes the bus pins arrive asynchronously and that mode and speed change only while idle.
// Contract
// - Data line stable while clock line high.
// - Data changes only while clock low.
// - Receiver samples data on clock rise.
// - Transmitter changes data just after clock fall.
// - Both lines high when bus idle.
// - Data fall with clock high starts transfer.
// - Data rise with clock high stops, release.
// - Host reads: command, repeated start, address.
// - Repeated start begins new address phase.
// - Port selectable as host or device.
// - Standard, fast, fast-plus speeds by configuration.
// - Inputs reject glitches up to 50 ns.
`timescale 1ns/1ps
`default_nettype none
module two_wire_port
  import two_wire_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  two_wire_if.port bus,
  input wire logic hostMode,
  input wire speed_t speedSel,
  input wire logic [ADDR_W-1:0] ownAddr,
  input wire logic cmdValid,
  input wire host_cmd_t cmdKind,
  input wire logic [BYTE_W-1:0] cmdData,
  input wire logic cmdAck,
  output logic busy,
  output logic cmdDone,
  output logic [BYTE_W-1:0] rdByte,
  output logic nackSeen,
  input wire logic [BYTE_W-1:0] txByte,
  output logic txTaken,
  output logic [BYTE_W-1:0] rxByte,
  output logic rxValid,
  output logic addrHit,
  output logic readDir,
  output logic startSeen,
  output logic stopSeen
);
  typedef enum logic [2:0] {T_IDLE, T_ADDR, T_RX, T_ACKOUT, T_TX, T_ACKIN, T_SKIP} dev_state_t;
  typedef enum logic [3:0] {H_IDLE, H_STA_A, H_STA_B, H_STA_C, H_DAT, H_LO, H_HI,
                            H_STP_A, H_STP_B, H_STP_C} host_state_t;

  // ==========================================================================
  // Input synchronisers and spike filters
  logic rawLine [2];
  logic syncA [2];
  logic syncB [2];
  logic filt [2];
  logic prevFilt [2];
  logic [2:0] filtCnt [2];

  assign rawLine[0] = bus.scl;
  assign rawLine[1] = bus.sda;

  for (genvar i = 0; i < 2; i++) begin : g_filt
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        syncA[i] <= 1'b1;
        syncB[i] <= 1'b1;
        filt[i] <= 1'b1;
        prevFilt[i] <= 1'b1;
        filtCnt[i] <= 3'h0;
      end else begin
        syncA[i] <= rawLine[i];
        syncB[i] <= syncA[i];
        prevFilt[i] <= filt[i];
        // A pulse shorter than the window never reaches the edge logic.
        if (syncB[i] == filt[i]) begin
          filtCnt[i] <= 3'h0;
        end else if (filtCnt[i] == FILT_LAST) begin
          filt[i] <= syncB[i];
          filtCnt[i] <= 3'h0;
        end else begin
          filtCnt[i] <= filtCnt[i] + 3'h1;
        end
      end
    end
  end

  wire logic sclF = filt[0];
  wire logic sdaF = filt[1];
  wire logic sclRise = filt[0] & ~prevFilt[0];
  wire logic sclFall = ~filt[0] & prevFilt[0];
  wire logic startEv = prevFilt[0] & filt[0] & prevFilt[1] & ~filt[1];
  wire logic stopEv = prevFilt[0] & filt[0] & ~prevFilt[1] & filt[1];

  // ==========================================================================
  // Device engine
  dev_state_t tState;
  logic [BYTE_W-1:0] tShift;
  logic [3:0] tBit;
  logic tPull;
  logic tRead;

  wire logic byteIn = (tState == T_ADDR || tState == T_RX) && sclFall && tBit == ACK_BIT;
  wire logic addrMatch = tShift[7:1] == ownAddr;
  wire logic loadTx = sclFall && ((tState == T_ACKOUT && tRead) ||
                                  (tState == T_ACKIN && !tShift[0]));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tState <= T_IDLE;
      tShift <= '0;
      tBit <= 4'h0;
      tPull <= 1'b0;
      tRead <= DIR_WRITE;
      rxByte <= '0;
      rxValid <= 1'b0;
      txTaken <= 1'b0;
      addrHit <= 1'b0;
      readDir <= DIR_WRITE;
      startSeen <= 1'b0;
      stopSeen <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      txTaken <= 1'b0;
      addrHit <= 1'b0;
      startSeen <= 1'b0;
      stopSeen <= 1'b0;
      if (hostMode) begin
        tState <= T_IDLE;
        tPull <= 1'b0;
      end else if (stopEv) begin
        tState <= T_IDLE;
        tPull <= 1'b0;
        stopSeen <= 1'b1;
      end else if (startEv) begin
        // A start seen mid-transfer is a repeated start: restart addressing.
        tState <= T_ADDR;
        tBit <= 4'h0;
        tPull <= 1'b0;
        startSeen <= 1'b1;
      end else if (loadTx) begin
        tShift <= {txByte[6:0], 1'b0};
        tPull <= ~txByte[7];
        tBit <= 4'h1;
        txTaken <= 1'b1;
        tState <= T_TX;
      end else if (byteIn) begin
        tBit <= 4'h0;
        if (tState == T_RX) begin
          rxByte <= tShift;
          rxValid <= 1'b1;
          tPull <= 1'b1;
          tState <= T_ACKOUT;
        end else if (addrMatch) begin
          tRead <= tShift[0];
          readDir <= tShift[0];
          addrHit <= 1'b1;
          tPull <= 1'b1;
          tState <= T_ACKOUT;
        end else begin
          tState <= T_SKIP;
        end
      end else begin
        unique case (tState)
          T_ADDR, T_RX: begin
            if (sclRise) begin
              tShift <= {tShift[6:0], sdaF};
              tBit <= tBit + 4'h1;
            end
          end
          T_ACKOUT: begin
            if (sclFall) begin
              tPull <= 1'b0;
              tState <= T_RX;
            end
          end
          T_TX: begin
            if (sclFall && tBit == ACK_BIT) begin
              tPull <= 1'b0;
              tState <= T_ACKIN;
            end else if (sclFall) begin
              tPull <= ~tShift[7];
              tShift <= {tShift[6:0], 1'b0};
              tBit <= tBit + 4'h1;
            end
          end
          T_ACKIN: begin
            if (sclRise) begin
              tShift[0] <= sdaF;
            end else if (sclFall) begin
              tState <= T_SKIP;
            end
          end
          T_IDLE, T_SKIP: begin
            tPull <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Host engine
  host_state_t hState;
  logic [HALF_W-1:0] tmr;
  logic [8:0] hShift;
  logic [3:0] hBit;
  logic hSclPull;
  logic hSdaPull;

  wire logic [HALF_W-1:0] halfCyc = (speedSel == SPEED_FAST) ? FAST_HALF_CYC :
                                    (speedSel == SPEED_FASTPLUS) ? FASTP_HALF_CYC :
                                    STD_HALF_CYC;
  wire logic tmrZero = tmr == '0;
  wire logic highDone = tmrZero && sclF && !sclRise;
  wire logic cmdTake = hostMode && cmdValid && hState == H_IDLE;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hState <= H_IDLE;
      tmr <= '0;
      hShift <= '0;
      hBit <= 4'h0;
      hSclPull <= 1'b0;
      hSdaPull <= 1'b0;
      busy <= 1'b0;
      cmdDone <= 1'b0;
      rdByte <= '0;
      nackSeen <= 1'b0;
    end else begin
      cmdDone <= 1'b0;
      tmr <= tmrZero ? tmr : tmr - HALF_W'(1);
      if (sclRise) begin
        // Timing of the high phase starts at the real rise, so stretching is honoured.
        tmr <= halfCyc;
      end
      unique case (hState)
        H_IDLE: begin
          if (cmdTake) begin
            busy <= 1'b1;
            tmr <= halfCyc;
            hBit <= 4'h0;
            hShift <= (cmdKind == CMD_READ) ? {RELEASE_BYTE, ~cmdAck} : {cmdData, 1'b1};
            unique case (cmdKind)
              CMD_START: hState <= H_STA_A;
              CMD_STOP: hState <= H_STP_A;
              CMD_WRITE, CMD_READ: hState <= H_DAT;
            endcase
          end
        end
        H_STA_A: begin
          hSdaPull <= 1'b0;
          if (tmrZero) begin
            hSclPull <= 1'b0;
            tmr <= halfCyc;
            hState <= H_STA_B;
          end
        end
        H_STA_B: begin
          if (highDone) begin
            hSdaPull <= 1'b1;
            tmr <= halfCyc;
            hState <= H_STA_C;
          end
        end
        H_STA_C: begin
          if (tmrZero) begin
            hSclPull <= 1'b1;
            busy <= 1'b0;
            cmdDone <= 1'b1;
            hState <= H_IDLE;
          end
        end
        H_DAT: begin
          hSdaPull <= ~hShift[8];
          tmr <= halfCyc;
          hState <= H_LO;
        end
        H_LO: begin
          if (tmrZero) begin
            hSclPull <= 1'b0;
            tmr <= halfCyc;
            hState <= H_HI;
          end
        end
        H_HI: begin
          if (sclRise) begin
            hShift <= {hShift[7:0], sdaF};
          end else if (highDone) begin
            hSclPull <= 1'b1;
            hBit <= hBit + 4'h1;
            if (hBit == ACK_BIT) begin
              rdByte <= hShift[8:1];
              nackSeen <= hShift[0];
              busy <= 1'b0;
              cmdDone <= 1'b1;
              hState <= H_IDLE;
            end else begin
              hState <= H_DAT;
            end
          end
        end
        H_STP_A: begin
          hSdaPull <= 1'b1;
          if (tmrZero) begin
            hSclPull <= 1'b0;
            tmr <= halfCyc;
            hState <= H_STP_B;
          end
        end
        H_STP_B: begin
          if (highDone) begin
            hSdaPull <= 1'b0;
            tmr <= halfCyc;
            hState <= H_STP_C;
          end
        end
        H_STP_C: begin
          if (tmrZero) begin
            busy <= 1'b0;
            cmdDone <= 1'b1;
            hState <= H_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Pin drivers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.portSclOut <= 1'b0;
      bus.portSdaOut <= 1'b0;
      bus.portSclOeN <= 1'b1;
      bus.portSdaOeN <= 1'b1;
    end else begin
      bus.portSclOut <= 1'b0;
      bus.portSdaOut <= 1'b0;
      bus.portSclOeN <= ~(hostMode & hSclPull);
      bus.portSdaOeN <= ~(hostMode ? hSdaPull : tPull);
    end
  end
endmodule
`default_nettype wire

// >>> verilog/two_wire_pkg.sv
// Constants and types shared by both ends of the two-wire serial link.
// Assumes a 100 MHz core clock on both ends.
package two_wire_pkg;
  // ==========================================================================
  // Clock and bus timing
  localparam int CLK_MHZ = 100;
  localparam int HALF_W = 10;
  localparam int STD_HALF_NS = 5000;
  localparam int FAST_HALF_NS = 1250;
  localparam int FASTP_HALF_NS = 500;
  localparam logic [HALF_W-1:0] STD_HALF_CYC = HALF_W'((STD_HALF_NS * CLK_MHZ + 999) / 1000);
  localparam logic [HALF_W-1:0] FAST_HALF_CYC = HALF_W'((FAST_HALF_NS * CLK_MHZ + 999) / 1000);
  localparam logic [HALF_W-1:0] FASTP_HALF_CYC = HALF_W'((FASTP_HALF_NS * CLK_MHZ + 999) / 1000);
  // A level change is accepted only after SPIKE_CYC + 1 equal samples.
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYC = (SPIKE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [2:0] FILT_LAST = 3'(SPIKE_CYC);
  localparam int CTRL_QUARTER_NS = 250;
  localparam logic [7:0] CTRL_QUARTER_CYC = 8'((CTRL_QUARTER_NS * CLK_MHZ + 999) / 1000);

  // ==========================================================================
  // Frame layout
  localparam int ADDR_W = 7;
  localparam int BYTE_W = 8;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic [7:0] RELEASE_BYTE = 8'hff;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {SPEED_STD, SPEED_FAST, SPEED_FASTPLUS} speed_t;
  typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP} host_cmd_t;
  typedef enum logic [1:0] {ST_START, ST_BYTE, ST_STOP} step_t;
endpackage

// >>> verilog/two_wire_if.sv
// Open-drain two-wire bus joining the port and the external controller.
// Each party drives an output and an active-low enable; a pull-up is implied.
`timescale 1ns/1ps
`default_nettype none
interface two_wire_if;
  logic portSclOut;
  logic portSclOeN;
  logic portSdaOut;
  logic portSdaOeN;
  logic ctrlSclOut;
  logic ctrlSclOeN;
  logic ctrlSdaOut;
  logic ctrlSdaOeN;
  wire logic scl;
  wire logic sda;

  // ==========================================================================
  // Wired-AND resolution
  assign scl = (portSclOeN | portSclOut) & (ctrlSclOeN | ctrlSclOut);
  assign sda = (portSdaOeN | portSdaOut) & (ctrlSdaOeN | ctrlSdaOut);

  modport port (input scl, input sda, output portSclOut, output portSclOeN,
                output portSdaOut, output portSdaOeN);
  modport ctrl (input scl, input sda, output ctrlSclOut, output ctrlSclOeN,
                output ctrlSdaOut, output ctrlSdaOeN);
endinterface
`default_nettype wire

// >>> verilog/two_wire_ctrl.sv
// External two-wire bus controller: writes a command and data, or reads one byte back.
// Assumes the target never stretches the clock; the clock line is made here by a divider.
`timescale 1ns/1ps
`default_nettype none
module two_wire_ctrl
  import two_wire_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  two_wire_if.ctrl bus,
  input wire logic reqValid,
  input wire logic reqRead,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [BYTE_W-1:0] reqCmd,
  input wire logic [BYTE_W-1:0] reqData,
  output logic busy,
  output logic done,
  output logic [BYTE_W-1:0] rdData,
  output logic nackErr
);
  // ==========================================================================
  // Data line synchroniser and quarter-bit divider
  logic sdaA;
  logic sdaS;
  logic [7:0] qCnt;
  logic [1:0] q;
  logic [2:0] step;
  logic [3:0] bitIx;
  logic [8:0] shift;
  logic isRead;
  logic [ADDR_W-1:0] addr;
  logic [BYTE_W-1:0] cmd;
  logic [BYTE_W-1:0] wdata;

  wire logic tick = busy && qCnt == CTRL_QUARTER_CYC - 8'h1;
  wire logic [2:0] lastStep = isRead ? 3'h6 : 3'h4;
  // A read sends the command, then a repeated start and the address again.
  wire step_t stepKind = (step == 3'h0 || (isRead && step == 3'h3)) ? ST_START :
                         (step == lastStep) ? ST_STOP : ST_BYTE;
  wire logic [BYTE_W-1:0] stepByte = (step == 3'h1) ? {addr, DIR_WRITE} :
                                     (step == 3'h2) ? cmd :
                                     (step == 3'h4) ? {addr, DIR_READ} :
                                     (isRead ? RELEASE_BYTE : wdata);
  wire logic rcvByte = isRead && step == 3'h5;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdaA <= 1'b1;
      sdaS <= 1'b1;
      qCnt <= 8'h0;
    end else begin
      sdaA <= bus.sda;
      sdaS <= sdaA;
      qCnt <= (tick || !busy) ? 8'h0 : qCnt + 8'h1;
    end
  end

  // ==========================================================================
  // Transfer sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      rdData <= '0;
      nackErr <= 1'b0;
      q <= 2'h0;
      step <= 3'h0;
      bitIx <= 4'h0;
      shift <= '0;
      isRead <= 1'b0;
      addr <= '0;
      cmd <= '0;
      wdata <= '0;
      bus.ctrlSclOut <= 1'b0;
      bus.ctrlSdaOut <= 1'b0;
      bus.ctrlSclOeN <= 1'b1;
      bus.ctrlSdaOeN <= 1'b1;
    end else begin
      done <= 1'b0;
      bus.ctrlSclOut <= 1'b0;
      bus.ctrlSdaOut <= 1'b0;
      if (!busy && reqValid) begin
        busy <= 1'b1;
        nackErr <= 1'b0;
        isRead <= reqRead;
        addr <= reqAddr;
        cmd <= reqCmd;
        wdata <= reqData;
        step <= 3'h0;
        q <= 2'h0;
        bitIx <= 4'h0;
      end else if (tick) begin
        q <= q + 2'h1;
        unique case (stepKind)
          ST_START: begin
            unique case (q)
              2'h0: bus.ctrlSdaOeN <= 1'b1;
              2'h1: bus.ctrlSclOeN <= 1'b1;
              2'h2: bus.ctrlSdaOeN <= 1'b0;
              2'h3: begin
                bus.ctrlSclOeN <= 1'b0;
                step <= step + 3'h1;
              end
            endcase
          end
          ST_BYTE: begin
            unique case (q)
              2'h0: begin
                if (bitIx == 4'h0) begin
                  shift <= {stepByte, 1'b1};
                  bus.ctrlSdaOeN <= stepByte[7];
                end else begin
                  bus.ctrlSdaOeN <= shift[8];
                end
              end
              2'h1: bus.ctrlSclOeN <= 1'b1;
              2'h2: shift <= {shift[7:0], sdaS};
              2'h3: begin
                bus.ctrlSclOeN <= 1'b0;
                bitIx <= (bitIx == ACK_BIT) ? 4'h0 : bitIx + 4'h1;
                if (bitIx == ACK_BIT && !rcvByte && shift[0]) begin
                  nackErr <= 1'b1;
                  step <= lastStep;
                end else if (bitIx == ACK_BIT) begin
                  if (rcvByte) begin
                    rdData <= shift[8:1];
                  end
                  step <= step + 3'h1;
                end
              end
            endcase
          end
          ST_STOP: begin
            unique case (q)
              2'h0: bus.ctrlSdaOeN <= 1'b0;
              2'h1: bus.ctrlSclOeN <= 1'b1;
              2'h2: bus.ctrlSdaOeN <= 1'b1;
              2'h3: begin
                busy <= 1'b0;
                done <= 1'b1;
              end
            endcase
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/two_wire_chk.sv
// Checker for the bus between the controller and the device port.
// Assumes the port is bus device and the controller is bus host on this bus.
`timescale 1ns/1ps
`default_nettype none
module two_wire_chk
  import two_wire_pkg::*;
#(
  parameter logic [ADDR_W-1:0] OWN_ADDR = 7'h00
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic portSclOeN,
  input wire logic portSdaOeN,
  input wire logic ctrlSdaOeN
);
  // ========================================
  // Bus events seen on the core clock
  logic sclQ, sdaQ, busActive;
  logic [3:0] riseCnt;
  logic [7:0] shReg, lowCnt;
  wire logic startEv = sclQ & scl & sdaQ & ~sda;
  wire logic stopEv = sclQ & scl & ~sdaQ & sda;
  wire logic riseEv = ~sclQ & scl;
  wire logic next_busActive = startEv | (busActive & ~stopEv);
  wire logic [3:0] next_riseCnt = startEv ? 4'h0 :
    (riseEv && riseCnt != 4'h9) ? riseCnt + 4'h1 : riseCnt;
  wire logic [7:0] next_shReg = riseEv ? {shReg[6:0], sda} : shReg;
  // Saturates so that a long low phase cannot wrap back into the legal window.
  wire logic [7:0] next_lowCnt = (sclQ & ~scl) ? 8'h00 :
    (!scl && lowCnt != 8'hff) ? lowCnt + 8'h01 : lowCnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
      busActive <= 1'b0;
      riseCnt <= 4'h9;
      shReg <= 8'h00;
      lowCnt <= 8'hff;
    end else begin
      sclQ <= scl;
      sdaQ <= sda;
      busActive <= next_busActive;
      riseCnt <= next_riseCnt;
      shReg <= next_shReg;
      lowCnt <= next_lowCnt;
    end
  end

  // ========================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_idle_high; !busActive && !startEv |-> scl && sda; endproperty
  a_idle_high: assert property (p_idle_high) else $error("bus not idle high");
  property p_rise_settled; riseEv |=> $stable(sda) [*4]; endproperty
  a_rise_settled: assert property (p_rise_settled) else $error("data moved at rise");
  property p_port_hold_high; scl && sclQ |-> $stable(portSdaOeN); endproperty
  a_port_hold_high: assert property (p_port_hold_high) else $error("port moved data");
  property p_port_change_low;
    $changed(portSdaOeN) |-> !scl && lowCnt >= 8'h02 && lowCnt <= 8'h28;
  endproperty
  a_port_change_low: assert property (p_port_change_low) else $error("late data");
  property p_dev_no_clock; portSclOeN; endproperty
  a_dev_no_clock: assert property (p_dev_no_clock) else $error("device drove clock");
  property p_addr_ack; riseEv && riseCnt == 4'h8 |-> sda == (shReg[7:1] != OWN_ADDR); endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
  property p_ctrl_release; riseEv && riseCnt == 4'h8 |-> ctrlSdaOeN; endproperty
  a_ctrl_release: assert property (p_ctrl_release) else $error("host held ack bit");
  property p_dev_no_start; startEv |-> !ctrlSdaOeN && portSdaOeN; endproperty
  a_dev_no_start: assert property (p_dev_no_start) else $error("start not from host");
  property p_stop_release; stopEv |=> (portSdaOeN && portSclOeN) [*8]; endproperty
  a_stop_release: assert property (p_stop_release) else $error("port held bus");

  c_restart: cover property (startEv && busActive);
  c_ack: cover property (riseEv && riseCnt == 4'h8 && !sda);
  c_stop: cover property (stopEv);
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Bench: controller and device port share one bus; a second port sits on a bench-driven bus.
// Assumes no device answers on the second bus, so its address bytes are refused.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import two_wire_pkg::*;
  localparam int LIMIT = 80000;
  localparam logic [ADDR_W-1:0] DEV_ADDR = 7'h3a;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reqValid = 1'b0, reqRead = 1'b0, hostModeB = 1'b0, cmdValid = 1'b0, cmdAck = 1'b0;
  logic [ADDR_W-1:0] reqAddr = 7'h00;
  logic [BYTE_W-1:0] reqCmd = 8'h00, reqData = 8'h00, cmdData = 8'h00, txByte = 8'h00;
  speed_t speedSel = SPEED_FAST;
  host_cmd_t cmdKind = CMD_START;
  logic ctrlDone, nackErr, busyA, rxValid, addrHit, readDir, startSeen, stopSeen;
  logic cmdDoneB, nackSeenB, startSeenB, stopSeenB, busyASeen = 1'b0;
  logic [BYTE_W-1:0] rdData, rxByte, rdByteB;
  wire logic anyDone = ctrlDone | cmdDoneB;
  int startCnt, stopCnt, hitCnt, startCntB, stopCntB, cycles, badCount, comparisons;
  logic bitQ[$];
  logic [BYTE_W-1:0] rxQ[$];
  realtime lastRise, periodNs;
  speed_t sp[3] = '{SPEED_STD, SPEED_FAST, SPEED_FASTPLUS};
  logic [HALF_W-1:0] hf[3] = '{STD_HALF_CYC, FAST_HALF_CYC, FASTP_HALF_CYC};
  two_wire_if busA();
  two_wire_if busB();

  always #5 clk = ~clk;

  two_wire_ctrl u_two_wire_ctrl (.clk(clk), .rst_n(rst_n), .bus(busA), .reqValid(reqValid),
    .reqRead(reqRead), .reqAddr(reqAddr), .reqCmd(reqCmd), .reqData(reqData), .busy(),
    .done(ctrlDone), .rdData(rdData), .nackErr(nackErr));
  two_wire_port u_two_wire_port (.clk(clk), .rst_n(rst_n), .bus(busA), .hostMode(1'b0),
    .speedSel(speedSel), .ownAddr(DEV_ADDR), .cmdValid(cmdValid), .cmdKind(cmdKind),
    .cmdData(cmdData), .cmdAck(cmdAck), .busy(busyA), .cmdDone(), .rdByte(), .nackSeen(),
    .txByte(txByte), .txTaken(), .rxByte(rxByte), .rxValid(rxValid), .addrHit(addrHit),
    .readDir(readDir), .startSeen(startSeen), .stopSeen(stopSeen));
  two_wire_port u_two_wire_port_b (.clk(clk), .rst_n(rst_n), .bus(busB), .hostMode(hostModeB),
    .speedSel(speedSel), .ownAddr(DEV_ADDR), .cmdValid(cmdValid), .cmdKind(cmdKind),
    .cmdData(cmdData), .cmdAck(cmdAck), .busy(), .cmdDone(cmdDoneB), .rdByte(rdByteB),
    .nackSeen(nackSeenB), .txByte(txByte), .txTaken(), .rxByte(), .rxValid(), .addrHit(),
    .readDir(), .startSeen(startSeenB), .stopSeen(stopSeenB));
  two_wire_chk #(.OWN_ADDR(DEV_ADDR)) u_two_wire_chk (.clk(clk), .rst_n(rst_n),
    .scl(busA.scl), .sda(busA.sda), .portSclOeN(busA.portSclOeN),
    .portSdaOeN(busA.portSdaOeN), .ctrlSdaOeN(busA.ctrlSdaOeN));

  // ========================================
  // Monitors
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (startSeen === 1'b1) startCnt <= startCnt + 1;
    if (stopSeen === 1'b1) stopCnt <= stopCnt + 1;
    if (addrHit === 1'b1) hitCnt <= hitCnt + 1;
    if (startSeenB === 1'b1) startCntB <= startCntB + 1;
    if (stopSeenB === 1'b1) stopCntB <= stopCntB + 1;
    if (rxValid === 1'b1) rxQ.push_back(rxByte);
    if (busyA === 1'b1) busyASeen <= 1'b1;
    if (cycles == LIMIT) begin
      badCount++;
      $display("[ERR] run length expected below %0d seen %0d", LIMIT, cycles);
      testDone();
    end
  end
  always @(posedge busA.scl) bitQ.push_back(busA.sda);
  always @(posedge busB.scl) begin
    periodNs = $realtime - lastRise;
    lastRise = $realtime;
  end

  // ========================================
  // Tasks
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic waitDone();
    int n;
    n = 0;
    while (anyDone !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    check("done", 9'h001, {8'h00, anyDone});
  endtask

  // Frame bits are read from the wire: eight data bits then the acknowledge bit.
  function automatic logic [8:0] frameAt(input int at);
    logic [8:0] v;
    for (int i = 0; i < 9; i++) v[8-i] = bitQ[at+i];
    return v;
  endfunction

  task automatic ctrlXfer(input logic rd, input logic [6:0] a, input logic [7:0] c,
                          input logic [7:0] d);
    bitQ.delete();
    rxQ.delete();
    startCnt = 0;
    stopCnt = 0;
    hitCnt = 0;
    reqRead <= rd;
    reqAddr <= a;
    reqCmd <= c;
    reqData <= d;
    reqValid <= 1'b1;
    @(posedge clk);
    reqValid <= 1'b0;
    waitDone();
    repeat (20) @(posedge clk);
  endtask

  task automatic hostCmd(input host_cmd_t k, input logic [7:0] d);
    cmdKind <= k;
    cmdData <= d;
    cmdValid <= 1'b1;
    @(posedge clk);
    cmdValid <= 1'b0;
    waitDone();
  endtask

  task automatic testDone();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ========================================
  // Sequence
  initial begin
    busB.ctrlSclOut = 1'b0;
    busB.ctrlSdaOut = 1'b0;
    busB.ctrlSclOeN = 1'b1;
    busB.ctrlSdaOeN = 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ctrlXfer(1'b0, DEV_ADDR, 8'h5c, 8'hc3);
    check("addr bits", {DEV_ADDR, DIR_WRITE, 1'b0}, frameAt(0));
    check("cmd bits", {8'h5c, 1'b0}, frameAt(9));
    check("data bits", {8'hc3, 1'b0}, frameAt(18));
    check("rx cmd", {1'b0, 8'h5c}, {1'b0, rxQ[0]});
    check("rx data", {1'b0, 8'hc3}, {1'b0, rxQ[1]});
    check("start stop hit", 9'h015, {3'h0, startCnt[1:0], stopCnt[1:0], hitCnt[1:0]});
    check("idle lines", 9'h003, {7'h00, busA.scl, busA.sda});
    check("nack dir", 9'h000, {7'h00, nackErr, readDir});
    $display("write test done");
    txByte <= 8'h96;
    ctrlXfer(1'b1, DEV_ADDR, 8'h21, 8'h00);
    check("restart addr", {DEV_ADDR, DIR_READ, 1'b0}, frameAt(19));
    check("read bits", {8'h96, 1'b1}, frameAt(28));
    check("read data", {1'b0, 8'h96}, {1'b0, rdData});
    check("start stop hit", 9'h026, {3'h0, startCnt[1:0], stopCnt[1:0], hitCnt[1:0]});
    check("read dir", 9'h001, {8'h00, readDir});
    $display("read test done");
    ctrlXfer(1'b0, DEV_ADDR ^ 7'h01, 8'h11, 8'h22);
    check("other addr", {DEV_ADDR ^ 7'h01, DIR_WRITE, 1'b1}, frameAt(0));
    check("nack hit rx", 9'h004, {6'h00, nackErr, hitCnt[0], rxQ.size() > 0});
    $display("wrong address test done");
    hostModeB <= 1'b1;
    cmdAck <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      speedSel <= sp[i];
      @(posedge clk);
      hostCmd(CMD_START, 8'h00);
      hostCmd(CMD_WRITE, {DEV_ADDR, DIR_WRITE});
      check("nack seen", 9'h001, {8'h00, nackSeenB});
      check("scl period", 9'h001, {8'h00, periodNs >= 20.0 * hf[i]
        && periodNs <= 10.0 * (2 * hf[i] + 40)});
      hostCmd(CMD_READ, 8'h00);
      check("host read", 9'h1fe, {rdByteB, nackSeenB});
      hostCmd(CMD_STOP, 8'h00);
      repeat (20) @(posedge clk);
      check("idle lines", 9'h003, {7'h00, busB.scl, busB.sda});
    end
    check("device ignores cmd", 9'h000, {8'h00, busyASeen});
    $display("host speed test done");
    hostModeB <= 1'b0;
    startCntB = 0;
    stopCntB = 0;
    @(posedge clk);
    busB.ctrlSdaOeN <= 1'b0;
    repeat (5) @(posedge clk);
    busB.ctrlSdaOeN <= 1'b1;
    repeat (30) @(posedge clk);
    check("glitch start", 9'h000, {7'h00, startCntB[1:0]});
    busB.ctrlSdaOeN <= 1'b0;
    repeat (30) @(posedge clk);
    busB.ctrlSdaOeN <= 1'b1;
    repeat (30) @(posedge clk);
    check("start stop", 9'h005, {5'h00, startCntB[1:0], stopCntB[1:0]});
    $display("glitch test done");
    testDone();
  end
endmodule
`default_nettype wire
